/* File: hdl/shf_byte_mem.v */
`timescale 1ns/10ps
// ************************************************
// byte store for the speech fifo, registered read
// ************************************************
module shf_byte_mem #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // shf_byte_mem

/* File: hdl/shf_host_io.v */
`timescale 1ns/10ps
// Functional notes
// - command and fifo take writes; data and status answer reads on one byte bus
// - writes go to fifo during external speech, else to command register
// - ready goes low once a written byte is latched or, with the fifo full, dropped
// - reads return data register after read-byte command, else status
// - sixteen byte fifo, shifted out serially oldest byte first
// - new byte goes just above the last written location
// - buffer low sets when fill drops to eight bytes
// - buffer low clears when ninth byte is written while talk is up
// - fifo empty during external speech sets empty flag, drops talk
// - empty sets as last bit leaves; writes then go to command register
// - fifo cleared at start of external speech, when it runs dry, reset, power-up
// - read-byte assembles rom serial bits into an eight bit register
// - read byte driven msb on d7, ready low once stable
// - status readable anytime except right after read-byte
// - status: talk on d7, buffer low on d6, empty on d5
// - talk rises on speak or after nine fifo bytes in external mode
// - talk falls on stop frame, buffer empty or reset command
// - after stop, output fades to frame boundary then stops
// - talk rises about 50 us after ninth byte
// - buffer low falls about 50 us after ninth byte if talk is not yet up
// - external command sets low and empty flags, interrupt, steers writes
// - both selects low act as a hardware clear
`include "shf_regs.vh"
module shf_host_io #(
    parameter DEPTH = `SHF_FIFO_DEPTH,
    parameter AW = 4,
    parameter DELAY_CYC = `SHF_TALK_DELAY_CYC
) (
    input wire core_clk,
    input wire rst_b,
    input wire write_select_n,
    input wire read_select_n,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    output reg ready_n,
    output reg int_n,
    // serial stream to synthesis
    input wire synth_bit_req,
    output reg synth_bit,
    output reg synth_bit_vld,
    // frame events from synthesis
    input wire frame_stop_seen,
    input wire frame_boundary,
    output reg audio_fade,
    output reg audio_on,
    // rom serial read path
    input wire rom_bit_vld,
    input wire rom_bit,
    output reg rom_byte_req,
    // command to the controller
    output reg [7:0] cmd_byte,
    output reg cmd_vld,
    input wire cmd_rdy
);
    // ************************************************
    // state
    // ************************************************
    reg [7:0] command_holding_r;
    reg [7:0] rom_read_byte_r;
    reg [3:0] rom_cnt_r;
    reg rom_byte_done_r;
    reg last_was_rdbyte_r;
    reg ext_mode_r;
    reg talk_flag_r;
    reg buffer_low_flag_r;
    reg buffer_empty_flag_r;
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] fill_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg shift_vld_r;
    reg [31:0] delay_cnt_r;
    reg delay_run_r;
    reg ws_d_r;
    reg rs_d_r;
    reg wr_pend_r;
    reg [7:0] wr_byte_r;
    reg mem_rd_pend_r;
    // ************************************************
    // two-entry skid in front of the command port
    // ************************************************
    reg [7:0] skid_data_r [0:1];
    reg [1:0] skid_cnt_r;
    reg skid_wp_r;
    reg skid_rp_r;

    wire hw_clear = !write_select_n && !read_select_n;
    wire ws_fall = !write_select_n && ws_d_r && read_select_n;
    wire rs_fall = !read_select_n && rs_d_r && write_select_n;
    // the byte in the shifter still counts as held, so capacity stays sixteen
    wire shifter_busy = shift_vld_r || mem_rd_pend_r;
    wire [AW:0] held = fill_r + {{AW{1'b0}}, shifter_busy};
    wire fifo_full = (held == DEPTH[AW:0]);
    wire [2:0] op = wr_byte_r[`SHF_CMD_OP_MSB:`SHF_CMD_OP_LSB];
    wire skid_full = (skid_cnt_r == 2'h2);
    wire to_fifo = wr_pend_r && ext_mode_r;
    wire to_cmd = wr_pend_r && !ext_mode_r && !skid_full;
    wire fifo_push = to_fifo && !fifo_full;
    wire need_load = !shift_vld_r && (fill_r != 0) && !mem_rd_pend_r && talk_flag_r;
    wire bit_take = synth_bit_vld && synth_bit_req;
    wire last_bit = bit_take && (bit_cnt_r == 3'h7);
    wire fifo_pop = need_load;
    wire ext_start = to_cmd && (op == `SHF_OP_SPEAK_EXT);
    wire do_reset = to_cmd && (op == `SHF_OP_RESET);
    wire ran_dry = ext_mode_r && talk_flag_r && last_bit && (fill_r == 0) && !mem_rd_pend_r;
    wire clear_fifo = hw_clear || do_reset || ext_start || ran_dry;
    wire [7:0] mem_q;
    wire [7:0] shift_nxt = mem_rd_pend_r ? mem_q :
                           (bit_take ? {1'b0, shift_r[7:1]} : shift_r);
    wire shift_vld_nxt = mem_rd_pend_r || (shift_vld_r && !last_bit);
    wire [AW:0] fill_nxt = fill_r + (fifo_push ? 1'b1 : 1'b0) - (fifo_pop ? 1'b1 : 1'b0);

    shf_byte_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .core_clk(core_clk),
        .wr_en(fifo_push),
        .wr_addr(wr_ptr_r),
        .wr_data(wr_byte_r),
        .rd_addr(rd_ptr_r),
        .rd_data(mem_q)
    );

    // ************************************************
    // host handshake
    // ************************************************
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ws_d_r <= 1'b1;
            rs_d_r <= 1'b1;
            wr_pend_r <= 1'b0;
            wr_byte_r <= 8'h00;
            ready_n <= 1'b1;
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
        end else begin
            ws_d_r <= write_select_n;
            rs_d_r <= read_select_n;
            if (hw_clear) begin
                wr_pend_r <= 1'b0;
                ready_n <= 1'b1;
                host_data_oe <= 1'b0;
            end else begin
                if (ws_fall) begin
                    wr_pend_r <= 1'b1;
                    wr_byte_r <= host_data_in;
                end else if (to_fifo || to_cmd) begin
                    wr_pend_r <= 1'b0;
                    ready_n <= 1'b0;
                end
                if (rs_fall) begin
                    host_data_oe <= 1'b1;
                    if (last_was_rdbyte_r) begin
                        host_data_out <= rom_read_byte_r;
                    end else begin
                        host_data_out <= 8'h00;
                        host_data_out[`SHF_STAT_TALK_BIT] <= talk_flag_r;
                        host_data_out[`SHF_STAT_LOW_BIT] <= buffer_low_flag_r;
                        host_data_out[`SHF_STAT_EMPTY_BIT] <= buffer_empty_flag_r;
                    end
                end else if (!read_select_n && host_data_oe &&
                             (!last_was_rdbyte_r || rom_byte_done_r)) begin
                    ready_n <= 1'b0;
                end
                if (read_select_n) begin
                    host_data_oe <= 1'b0;
                end
                if (read_select_n && write_select_n) begin
                    ready_n <= 1'b1;
                end
            end
        end
    end

    // ************************************************
    // command skid buffer
    // ************************************************
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            skid_cnt_r <= 2'h0;
            skid_wp_r <= 1'b0;
            skid_rp_r <= 1'b0;
            skid_data_r[0] <= 8'h00;
            skid_data_r[1] <= 8'h00;
            cmd_byte <= 8'h00;
            cmd_vld <= 1'b0;
            command_holding_r <= 8'h00;
        end else begin
            if (to_cmd) begin
                skid_data_r[skid_wp_r] <= wr_byte_r;
                skid_wp_r <= ~skid_wp_r;
                command_holding_r <= wr_byte_r;
            end
            if (!cmd_vld || cmd_rdy) begin
                cmd_vld <= (skid_cnt_r != 2'h0);
                cmd_byte <= skid_data_r[skid_rp_r];
                if (skid_cnt_r != 2'h0) begin
                    skid_rp_r <= ~skid_rp_r;
                end
            end
            skid_cnt_r <= skid_cnt_r + (to_cmd ? 2'h1 : 2'h0)
                - (((!cmd_vld || cmd_rdy) && skid_cnt_r != 2'h0) ? 2'h1 : 2'h0);
        end
    end

    // ************************************************
    // mode and flags
    // ************************************************
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_mode_r <= 1'b0;
            talk_flag_r <= 1'b0;
            buffer_low_flag_r <= 1'b1;
            buffer_empty_flag_r <= 1'b1;
            int_n <= 1'b1;
            last_was_rdbyte_r <= 1'b0;
            delay_cnt_r <= 32'h0;
            delay_run_r <= 1'b0;
            audio_fade <= 1'b0;
            audio_on <= 1'b0;
        end else if (hw_clear || do_reset) begin
            ext_mode_r <= 1'b0;
            talk_flag_r <= 1'b0;
            buffer_low_flag_r <= 1'b1;
            buffer_empty_flag_r <= 1'b1;
            int_n <= 1'b1;
            last_was_rdbyte_r <= 1'b0;
            delay_run_r <= 1'b0;
            audio_fade <= 1'b0;
            audio_on <= 1'b0;
        end else begin
            if (to_cmd) begin
                last_was_rdbyte_r <= (op == `SHF_OP_READ_BYTE);
                if (op == `SHF_OP_SPEAK) begin
                    talk_flag_r <= 1'b1;
                end
            end
            if (ext_start) begin
                ext_mode_r <= 1'b1;
                buffer_low_flag_r <= 1'b1;
                buffer_empty_flag_r <= 1'b1;
                int_n <= 1'b0;
            end else begin
                if (rs_fall) begin
                    int_n <= 1'b1;
                end
                if (fifo_push && fill_r != 0) begin
                    buffer_empty_flag_r <= 1'b0;
                end
                if (fifo_push && fill_r == 0) begin
                    buffer_empty_flag_r <= 1'b0;
                end
                if (fifo_push && fill_nxt == `SHF_START_LEVEL && !delay_run_r) begin
                    delay_run_r <= 1'b1;
                    delay_cnt_r <= 32'h0;
                end
                if (delay_run_r) begin
                    delay_cnt_r <= delay_cnt_r + 32'h1;
                    if (delay_cnt_r == DELAY_CYC - 1) begin
                        delay_run_r <= 1'b0;
                        buffer_low_flag_r <= 1'b0;
                        if (!talk_flag_r) begin
                            talk_flag_r <= 1'b1;
                        end
                    end
                end else if (fifo_push && held >= `SHF_LOW_LEVEL && talk_flag_r) begin
                    buffer_low_flag_r <= 1'b0;
                end
                if (last_bit && held == `SHF_LOW_LEVEL + 1 && !fifo_push) begin
                    buffer_low_flag_r <= 1'b1;
                end
                if (ran_dry) begin
                    buffer_empty_flag_r <= 1'b1;
                    talk_flag_r <= 1'b0;
                    ext_mode_r <= 1'b0;
                    audio_on <= 1'b0;
                end else if (frame_stop_seen && talk_flag_r) begin
                    audio_fade <= 1'b1;
                end
                if (audio_fade && frame_boundary) begin
                    audio_fade <= 1'b0;
                    audio_on <= 1'b0;
                    talk_flag_r <= 1'b0;
                    ext_mode_r <= 1'b0;
                end else if (talk_flag_r && frame_boundary && !audio_fade) begin
                    audio_on <= 1'b1;
                end
            end
        end
    end

    // ************************************************
    // fifo pointers and serial shifter
    // ************************************************
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            fill_r <= {(AW+1){1'b0}};
            mem_rd_pend_r <= 1'b0;
            shift_r <= 8'h00;
            shift_vld_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            synth_bit <= 1'b0;
            synth_bit_vld <= 1'b0;
        end else if (clear_fifo) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            fill_r <= {(AW+1){1'b0}};
            mem_rd_pend_r <= 1'b0;
            shift_vld_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            synth_bit_vld <= 1'b0;
        end else begin
            if (fifo_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            fill_r <= fill_nxt;
            mem_rd_pend_r <= fifo_pop;
            if (fifo_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (mem_rd_pend_r) begin
                bit_cnt_r <= 3'h0;
            end else if (bit_take) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            shift_r <= shift_nxt;
            shift_vld_r <= shift_vld_nxt;
            // outputs show the bit that the next take consumes
            synth_bit <= shift_nxt[0];
            synth_bit_vld <= shift_vld_nxt && talk_flag_r;
        end
    end

    // ************************************************
    // rom byte assembly
    // ************************************************
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rom_read_byte_r <= 8'h00;
            rom_cnt_r <= 4'h0;
            rom_byte_done_r <= 1'b0;
            rom_byte_req <= 1'b0;
        end else if (hw_clear) begin
            rom_cnt_r <= 4'h0;
            rom_byte_done_r <= 1'b0;
            rom_byte_req <= 1'b0;
        end else if (to_cmd && op == `SHF_OP_READ_BYTE) begin
            rom_cnt_r <= 4'h0;
            rom_byte_done_r <= 1'b0;
            rom_byte_req <= 1'b1;
        end else if (rom_byte_req && rom_bit_vld) begin
            rom_read_byte_r <= {rom_read_byte_r[6:0], rom_bit};
            rom_cnt_r <= rom_cnt_r + 4'h1;
            if (rom_cnt_r == 4'h7) begin
                rom_byte_req <= 1'b0;
                rom_byte_done_r <= 1'b1;
            end
        end
    end
endmodule // shf_host_io

/* File: hdl/shf_regs.vh */
`ifndef SHF_REGS_VH
`define SHF_REGS_VH
// ************************************************
// command byte fields
// ************************************************
`define SHF_CMD_OP_MSB 6
`define SHF_CMD_OP_LSB 4
`define SHF_OP_SPEAK 3'h5
`define SHF_OP_SPEAK_EXT 3'h6
`define SHF_OP_READ_BYTE 3'h1
`define SHF_OP_RESET 3'h7
// ************************************************
// status bit positions on the bus
// ************************************************
`define SHF_STAT_TALK_BIT 7
`define SHF_STAT_LOW_BIT 6
`define SHF_STAT_EMPTY_BIT 5
// ************************************************
// fifo and timing
// ************************************************
`define SHF_FIFO_DEPTH 16
`define SHF_LOW_LEVEL 8
`define SHF_START_LEVEL 9
`define SHF_CLK_MHZ 200
`define SHF_TALK_DELAY_US 50
`define SHF_TALK_DELAY_CYC (`SHF_TALK_DELAY_US * `SHF_CLK_MHZ)
`define SHF_STOP_ENERGY 4'hf
`endif

/* File: verif/shf_host_io_asserts.sv */
`timescale 1ns/10ps
// ************************************************
// port checks for the host io block
// ************************************************
module shf_host_io_chk (
    input wire core_clk,
    input wire rst_b,
    input wire write_select_n,
    input wire read_select_n,
    input wire [7:0] host_data_out,
    input wire host_data_oe,
    input wire ready_n,
    input wire synth_bit_req,
    input wire synth_bit,
    input wire synth_bit_vld,
    input wire frame_boundary,
    input wire audio_fade,
    input wire audio_on,
    input wire rom_bit_vld,
    input wire rom_byte_req,
    input wire [7:0] cmd_byte,
    input wire cmd_vld,
    input wire cmd_rdy
);
    reg [3:0] rb_cnt_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // rom bits taken in one fetch
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) rb_cnt_r <= 4'h0;
        else if (rom_byte_req) rb_cnt_r <= rb_cnt_r + {3'h0, rom_bit_vld};
        else rb_cnt_r <= 4'h0;
    end
    a_ready_release: assert property (write_select_n && read_select_n |=> ready_n)
        else $error("ready stuck low");
    a_write_latch: assert property ($fell(write_select_n) && read_select_n |-> ready_n [*2])
        else $error("write ready too early");
    a_read_answer: assert property ($fell(read_select_n) && write_select_n && !rom_byte_req
        |-> ##[1:4] !ready_n)
        else $error("read not answered");
    a_oe_at_ready: assert property ($fell(ready_n) && !read_select_n && write_select_n
        |-> host_data_oe)
        else $error("ready before data driven");
    a_oe_release: assert property (read_select_n |=> !host_data_oe)
        else $error("bus driven without read");
    a_data_stands: assert property (host_data_oe && !ready_n && !read_select_n
        |=> $stable(host_data_out))
        else $error("read data moved");
    a_bit_hold: assert property (synth_bit_vld && !synth_bit_req && (write_select_n || read_select_n)
        |=> synth_bit_vld && $stable(synth_bit))
        else $error("serial bit lost");
    a_hw_clear: assert property (!write_select_n && !read_select_n |-> ##[1:2] !synth_bit_vld)
        else $error("clear left fifo data");
    a_rom_count: assert property ($fell(rom_byte_req) |-> rb_cnt_r == 4'h8)
        else $error("rom fetch not eight bits");
    a_audio_stop: assert property (audio_fade && frame_boundary |=> !audio_on)
        else $error("audio past boundary");
    a_cmd_hold: assert property (cmd_vld && !cmd_rdy |=> cmd_vld && $stable(cmd_byte))
        else $error("command dropped");
    c_bit_taken: cover property (synth_bit_vld && synth_bit_req);
    c_rom_done: cover property ($fell(rom_byte_req));
    c_cmd_stall: cover property (cmd_vld && !cmd_rdy);
endmodule // shf_host_io_chk

bind shf_host_io shf_host_io_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .write_select_n(write_select_n), .read_select_n(read_select_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ready_n(ready_n),
    .synth_bit_req(synth_bit_req), .synth_bit(synth_bit), .synth_bit_vld(synth_bit_vld),
    .frame_boundary(frame_boundary), .audio_fade(audio_fade), .audio_on(audio_on),
    .rom_bit_vld(rom_bit_vld), .rom_byte_req(rom_byte_req), .cmd_byte(cmd_byte),
    .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy));

/* File: verif/shf_host_io_tb_top.sv */
`timescale 1ns/10ps
module shf_host_io_tb_top;
    localparam DLY = 20;
    // cmd, stop sequence, mask, status
    localparam logic [24:0] ROWS [0:4] = '{{8'h70, 1'b0, 8'hff, 8'h60},
        {8'h50, 1'b0, 8'h80, 8'h80}, {8'h70, 1'b0, 8'hff, 8'h60},
        {8'h50, 1'b1, 8'h80, 8'h00}, {8'h70, 1'b0, 8'hff, 8'h60}};
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg synth_bit_req = 1'b0;
    reg frame_stop_seen = 1'b0;
    reg frame_boundary = 1'b0;
    reg rom_bit_vld = 1'b0;
    reg rom_bit = 1'b0;
    reg cmd_rdy = 1'b1;
    wire write_select_n, read_select_n, host_data_oe, ready_n, int_n, h_en;
    wire synth_bit, synth_bit_vld, audio_fade, audio_on, rom_byte_req, cmd_vld;
    wire [7:0] host_data_out, cmd_byte, h_d;
    // bus has pull-ups when nobody drives
    wire [7:0] host_data_in = host_data_oe ? host_data_out : (h_en ? h_d : 8'hff);
    integer n_mismatch = 0, checks = 0, bi = 0, cn = 0, c0, i;
    reg [7:0] q;
    reg ok;
    reg [127:0] got;
    reg [7:0] cmd_log [0:31];
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (cmd_vld === 1'b1 && cmd_rdy) begin
        cmd_log[cn % 32] <= cmd_byte;
        cn <= cn + 1;
    end
    shf_host_io #(.DELAY_CYC(DLY)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .write_select_n(write_select_n), .read_select_n(read_select_n),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .ready_n(ready_n), .int_n(int_n),
        .synth_bit_req(synth_bit_req), .synth_bit(synth_bit), .synth_bit_vld(synth_bit_vld),
        .frame_stop_seen(frame_stop_seen), .frame_boundary(frame_boundary),
        .audio_fade(audio_fade), .audio_on(audio_on), .rom_bit_vld(rom_bit_vld),
        .rom_bit(rom_bit), .rom_byte_req(rom_byte_req), .cmd_byte(cmd_byte),
        .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy));
    shf_host_model host (.core_clk(core_clk), .ready_n(ready_n), .bus(host_data_in),
        .write_select_n(write_select_n), .read_select_n(read_select_n),
        .drv_data(h_d), .drv_en(h_en));
    task chk(input [7:0] g, input [7:0] e, input [7:0] m);
        begin
            checks = checks + 1;
            if ((g & m) !== (e & m)) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] d);
        begin
            host.xfer(1'b0, d, 40, q, ok);
            chk({7'h0, ok}, 8'h01, 8'h01);
        end
    endtask
    task rd_st(input [7:0] e, input [7:0] m);
        begin
            host.xfer(1'b1, 8'h00, 40, q, ok);
            chk(q, e, m);
        end
    endtask
    task frame(input stop);
        begin
            frame_stop_seen <= stop;
            frame_boundary <= !stop;
            @(posedge core_clk);
            frame_stop_seen <= 1'b0;
            frame_boundary <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task rom_feed(input [7:0] p);
        integer k;
        begin
            k = 0;
            while (rom_byte_req !== 1'b1 && k < 50) begin
                @(posedge core_clk);
                k = k + 1;
            end
            for (k = 7; k >= 0; k = k - 1) begin
                rom_bit_vld <= 1'b1;
                rom_bit <= p[k];
                @(posedge core_clk);
            end
            rom_bit_vld <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask
    // synthesis side pulls bits, then stalls
    task drain(input integer nb);
        integer k, g;
        begin
            k = 0;
            g = 0;
            synth_bit_req <= 1'b1;
            while (k < nb && g < 400) begin
                @(posedge core_clk);
                g = g + 1;
                if (synth_bit_vld === 1'b1) begin
                    got[bi] = synth_bit;
                    bi = bi + 1;
                    k = k + 1;
                end
            end
            synth_bit_req <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // whole run is about 600 cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t watchdog", $time);
        final_report;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({5'h0, ready_n, host_data_oe, int_n}, 8'h05, 8'h07);
        rd_st(8'h60, 8'hff);
        wr(8'h10);
        chk({7'h0, rom_byte_req}, 8'h01, 8'h01);
        rom_feed(8'ha5);
        rd_st(8'ha5, 8'hff);
        wr(8'h70);
        rd_st(8'h60, 8'hff);
        $display("test reset and read byte done");
        for (i = 0; i < 5; i = i + 1) begin
            wr(ROWS[i][24:17]);
            if (ROWS[i][16]) begin
                frame(1'b0);
                frame(1'b1);
                chk({7'h0, audio_fade}, 8'h01, 8'h01);
                frame(1'b0);
                chk({7'h0, audio_on}, 8'h00, 8'h01);
            end
            rd_st(ROWS[i][7:0], ROWS[i][15:8]);
        end
        $display("test command rows done");
        wr(8'h60);
        chk({7'h0, int_n}, 8'h00, 8'h01);
        rd_st(8'h60, 8'he0);
        c0 = cn;
        for (i = 0; i < 9; i = i + 1) wr(8'h30 + i[7:0]);
        rd_st(8'h40, 8'hc0);
        repeat (DLY + 4) @(posedge core_clk);
        rd_st(8'h80, 8'hc0);
        for (i = 9; i < 17; i = i + 1) wr(8'h30 + i[7:0]);
        chk(cn[7:0], c0[7:0], 8'hff);
        drain(56);
        rd_st(8'h80, 8'hc0);
        drain(8);
        rd_st(8'hc0, 8'hc0);
        drain(64);
        rd_st(8'h60, 8'he0);
        for (i = 0; i < 16; i = i + 1) chk(got[i*8 +: 8], 8'h30 + i[7:0], 8'hff);
        chk({7'h0, synth_bit_vld}, 8'h00, 8'h01);
        wr(8'h44);
        repeat (4) @(posedge core_clk);
        chk(cmd_log[(cn - 1) % 32], 8'h44, 8'hff);
        wr(8'h60);
        wr(8'h55);
        host.hwclr;
        wr(8'h70);
        rd_st(8'h60, 8'hff);
        $display("test external speech done");
        cmd_rdy <= 1'b0;
        c0 = cn;
        wr(8'h41);
        wr(8'h42);
        wr(8'h43);
        fork
            host.xfer(1'b0, 8'h44, 80, q, ok);
            begin
                repeat (20) @(posedge core_clk);
                chk({7'h0, ready_n}, 8'h01, 8'h01);
                cmd_rdy <= 1'b1;
            end
        join
        chk({7'h0, ok}, 8'h01, 8'h01);
        repeat (4) @(posedge core_clk);
        for (i = 0; i < 4; i = i + 1) chk(cmd_log[(c0 + i) % 32], 8'h41 + i[7:0], 8'hff);
        $display("test command stall done");
        final_report;
    end
endmodule // shf_host_io_tb_top

/* File: verif/shf_host_model.sv */
`timescale 1ns/10ps
// ************************************************
// host cpu on the byte bus
// ************************************************
module shf_host_model (
    input wire core_clk,
    input wire ready_n,
    input wire [7:0] bus,
    output reg write_select_n,
    output reg read_select_n,
    output reg [7:0] drv_data,
    output reg drv_en
);
    initial begin
        write_select_n = 1'b1;
        read_select_n = 1'b1;
        drv_data = 8'hff;
        drv_en = 1'b0;
    end
    // select and data held until ready is seen low at an edge
    task xfer(input rd, input [7:0] d, input integer lim, output [7:0] q, output ok);
        integer n;
        begin
            n = 0;
            ok = 1'b0;
            q = 8'h00;
            @(posedge core_clk);
            read_select_n <= !rd;
            write_select_n <= rd;
            drv_data <= d;
            drv_en <= !rd;
            while (!ok && n < lim) begin
                @(posedge core_clk);
                n = n + 1;
                if (ready_n === 1'b0) begin
                    ok = 1'b1;
                    q = bus;
                end
            end
            read_select_n <= 1'b1;
            write_select_n <= 1'b1;
            drv_en <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask
    // both selects low clears the device
    task hwclr;
        begin
            @(posedge core_clk);
            read_select_n <= 1'b0;
            write_select_n <= 1'b0;
            repeat (4) @(posedge core_clk);
            read_select_n <= 1'b1;
            write_select_n <= 1'b1;
            repeat (3) @(posedge core_clk);
        end
    endtask
endmodule // shf_host_model
